/* File: logic/plc_pkg.sv */
// constants and types shared by the loop control block
package plc_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_MULT      = 8'h00;
  localparam logic [7:0]  OFS_PRE       = 8'h04;
  localparam logic [7:0]  OFS_POST0     = 8'h08;
  localparam logic [7:0]  OFS_POST1     = 8'h0c;
  localparam logic [7:0]  OFS_POST2     = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h1c;

  // ------------------------------------------------------------
  // divider settings
  // ------------------------------------------------------------
  localparam int          DIV_W         = 6;
  localparam int          POST_NUM      = 3;
  localparam logic [5:0]  DIV_ONE       = 6'h01;
  localparam logic [5:0]  MULT_MAX      = 6'h20;
  localparam logic [5:0]  PRE_MAX       = 6'h04;
  localparam logic [5:0]  POST_MAX      = 6'h20;
  localparam logic [5:0]  MULT_RST      = 6'h04;
  localparam logic [5:0]  PRE_RST       = 6'h01;
  localparam logic [5:0]  POST_RST      = 6'h02;

  // ------------------------------------------------------------
  // oscillator model and lock detection
  // ------------------------------------------------------------
  localparam int          VCO_W          = 16;
  localparam logic [15:0] VCO_ONE        = 16'h0001;
  localparam logic [15:0] VCO_PERIOD_RST = 16'h0008;
  localparam logic [15:0] VCO_PERIOD_MIN = 16'h0001;
  localparam logic [15:0] VCO_PERIOD_MAX = 16'hffff;
  localparam int          WAIT_W         = 8;
  localparam logic [7:0]  WAIT_ONE       = 8'h01;
  localparam logic [7:0]  WAIT_MAX       = 8'hff;
  localparam logic [7:0]  LOCK_WINDOW    = 8'h02;
  localparam logic [7:0]  LOCK_ONE       = 8'h01;
  localparam logic [7:0]  LOCK_LAST      = 8'h0f;

  // ------------------------------------------------------------
  // status and interrupt bits
  // ------------------------------------------------------------
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_LOCK_GAIN = 0;
  localparam int          IRQ_LOCK_LOSS = 1;
  localparam int          IRQ_SWITCH    = 2;
  localparam int          ST_LOCKED     = 0;
  localparam int          ST_REF_SEL    = 1;
  localparam int          ST_RUNNING    = 2;
  localparam int          ST_PD_EN      = 3;

  typedef enum logic [1:0] {LD_IDLE, LD_COUNT, LD_LOCKED} plc_lock_state_t;

endpackage

/* File: logic/plc_post_div.sv */
// counter that divides a tick stream and toggles a clock level
`timescale 1ns/10ps
module plc_post_div (
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     srst,
  input  wire logic                     clear,
  input  wire logic                     tick,
  input  wire logic [plc_pkg::DIV_W-1:0] divVal,
  output logic                          pulse,
  output logic                          level
);

  typedef struct packed {
    logic [plc_pkg::DIV_W-1:0] cnt;
    logic                      pulse;
    logic                      level;
  } plc_div_state_t;

  plc_div_state_t st_reg;
  plc_div_state_t st_next;

  // ------------------------------------------------------------
  // count
  // ------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (clear) begin
      st_next = '0; // [RULE4]
    end else if (tick) begin
      if (st_reg.cnt >= divVal - plc_pkg::DIV_ONE) begin
        st_next.cnt   = '0;
        st_next.pulse = 1'b1;
        st_next.level = ~st_reg.level;
      end else begin
        st_next.cnt = st_reg.cnt + plc_pkg::DIV_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pulse = st_reg.pulse;
  assign level = st_reg.level;

  a_div_clear: assert property (@(posedge clk) disable iff (srst) // [RULE4]
    (ce && clear) |=> (!level && !pulse && st_reg.cnt == '0))
    else $error("divider not cleared");

endmodule

/* File: logic/plc_lock_det.sv */
// lock detector counting consecutive matched phase comparisons
`timescale 1ns/10ps
module plc_lock_det (
  input  wire logic clk,
  input  wire logic ce,
  input  wire logic srst,
  input  wire logic clear,
  input  wire logic match,
  input  wire logic miss,
  output logic      locked
);

  typedef struct packed {
    plc_pkg::plc_lock_state_t        fsm;
    logic [plc_pkg::WAIT_W-1:0]      cnt;
    logic                            locked;
  } plc_ld_state_t;

  plc_ld_state_t st_reg;
  plc_ld_state_t st_next;

  // ------------------------------------------------------------
  // lock state machine
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg.fsm)
      plc_pkg::LD_IDLE: begin
        if (match) begin
          st_next.fsm = plc_pkg::LD_COUNT;
          st_next.cnt = plc_pkg::LOCK_ONE;
        end
      end
      plc_pkg::LD_COUNT: begin
        if (miss) begin
          st_next.fsm = plc_pkg::LD_IDLE;
          st_next.cnt = '0;
        end else if (match) begin
          if (st_reg.cnt == plc_pkg::LOCK_LAST) begin
            st_next.fsm = plc_pkg::LD_LOCKED; // [RULE15]
          end else begin
            st_next.cnt = st_reg.cnt + plc_pkg::LOCK_ONE;
          end
        end
      end
      plc_pkg::LD_LOCKED: begin
        if (miss) begin
          st_next.fsm = plc_pkg::LD_IDLE; // [RULE11]
          st_next.cnt = '0;
        end
      end
      default: begin
        st_next.fsm = plc_pkg::LD_IDLE;
      end
    endcase
    if (clear) begin
      st_next.fsm = plc_pkg::LD_IDLE; // [RULE15]
      st_next.cnt = '0;
    end
    st_next.locked = (st_next.fsm == plc_pkg::LD_LOCKED); // [RULE10]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign locked = st_reg.locked;

  a_lock_after_run: assert property (@(posedge clk) disable iff (srst) // [RULE15]
    $rose(locked) |-> ($past(st_reg.cnt) == plc_pkg::LOCK_LAST && $past(match)))
    else $error("lock declared before full run of matches");

  a_miss_drops: assert property (@(posedge clk) disable iff (srst) // [RULE10]
    (ce && miss) |=> !locked)
    else $error("lock held after a missed comparison");

endmodule

/* File: logic/plc_loop_ctrl.sv */
// control, status and register port of the phase-locked loop model
// ------------------------------------------------------------
// Functional notes
// [RULE1] loop enable is active high, enabling and resetting the loop
// [RULE2] enable low forces every output clock low and drops lock
// [RULE3] enable high again starts a fresh acquisition on the reference
// [RULE4] counter reset high clears dividers, output clocks and lock
// [RULE5] counter reset release restarts lock acquisition
// [RULE6] phase detector enable gates up and down; oscillator keeps running
// [RULE7] switchover request level starts a change to the other reference; the code acts only on the rising edge of switchRequest
// [RULE8] primary or secondary reference feeds the pre-scale divider
// [RULE9] references come only from their dedicated clock input pins
// [RULE10] lock output is high while locked, low while out of lock
// [RULE11] lock may pulse during acquisition; consumers must filter it
// [RULE12] third output also drives the external clock pin
// [RULE13] control inputs may come from logic cells or input pins
// [RULE14] multiply and post counters take 1 to 32, pre-scale 1 to 4
// [RULE15] lock after a run of matched comparisons, cleared by any reset
// ------------------------------------------------------------
`timescale 1ns/10ps
module plc_loop_ctrl (
  input  wire logic                        clk,
  input  wire logic                        ce,
  input  wire logic                        srst,
  input  wire logic                        pllEnable,
  input  wire logic                        counterReset,
  input  wire logic                        phaseDetEnable,
  input  wire logic                        switchRequest,
  input  wire logic                        refPrimary,
  input  wire logic                        refSecondary,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [plc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [plc_pkg::DATA_W-1:0]  pwdata,
  output logic      [plc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [plc_pkg::POST_NUM-1:0] clkOut,
  output logic                             extClkOut,
  output logic                             locked,
  output logic                             irq
);

  typedef struct packed {
    logic                                          refPrev;
    logic                                          activeRef;
    logic                                          swPrev;
    logic [plc_pkg::VCO_W-1:0]                     vcoCnt;
    logic [plc_pkg::VCO_W-1:0]                     vcoPeriod;
    logic                                          upPend;
    logic                                          dnPend;
    logic [plc_pkg::WAIT_W-1:0]                    waitCnt;
    logic [plc_pkg::DIV_W-1:0]                     multVal;
    logic [plc_pkg::DIV_W-1:0]                     preVal;
    logic [plc_pkg::POST_NUM-1:0][plc_pkg::DIV_W-1:0] postVal;
    logic [plc_pkg::IRQ_W-1:0]                     irqStat;
    logic [plc_pkg::IRQ_W-1:0]                     irqMask;
    logic                                          lockPrev;
    logic                                          pready;
    logic                                          pslverr;
    logic [plc_pkg::DATA_W-1:0]                    prdata;
    logic [plc_pkg::POST_NUM-1:0]                  clkOut;
    logic                                          extClk;
    logic                                          locked;
    logic                                          irq;
  } plc_ctrl_state_t;

  plc_ctrl_state_t st_reg;
  plc_ctrl_state_t st_next;

  logic                          running;
  logic                          refSel;
  logic                          refEdge;
  logic                          vcoTick;
  logic                          refTick;
  logic                          fbTick;
  logic                          switchEdge;
  logic                          pdMatch;
  logic                          pdMiss;
  logic                          resync;
  logic                          lockDet;
  logic [plc_pkg::POST_NUM-1:0]  postLevel;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic inRange(input logic [plc_pkg::DIV_W-1:0] v,
                                   input logic [plc_pkg::DIV_W-1:0] hi);
    return (v >= plc_pkg::DIV_ONE) && (v <= hi);
  endfunction

  function automatic logic [plc_pkg::DATA_W-1:0] widen(input logic [plc_pkg::DIV_W-1:0] v);
    return {{(plc_pkg::DATA_W-plc_pkg::DIV_W){1'b0}}, v};
  endfunction

  // ------------------------------------------------------------
  // reference select and edge detect
  // ------------------------------------------------------------
  assign running    = pllEnable && !counterReset; // [RULE1]
  assign refSel     = st_reg.activeRef ? refSecondary : refPrimary; // [RULE8]
  assign refEdge    = running && refSel && !st_reg.refPrev;
  assign vcoTick    = running && (st_reg.vcoCnt >= st_reg.vcoPeriod - plc_pkg::VCO_ONE);
  assign switchEdge = switchRequest && !st_reg.swPrev; // [RULE7]

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  plc_post_div u_pre_div (
    .clk    (clk),
    .ce     (ce),
    .srst   (srst),
    .clear  (!running),
    .tick   (refEdge),
    .divVal (st_reg.preVal),
    .pulse  (refTick),
    .level  ()
  );

  plc_post_div u_fb_div (
    .clk    (clk),
    .ce     (ce),
    .srst   (srst),
    .clear  (!running || resync),
    .tick   (vcoTick),
    .divVal (st_reg.multVal),
    .pulse  (fbTick),
    .level  ()
  );

  genvar gi;
  generate
    for (gi = 0; gi < plc_pkg::POST_NUM; gi++) begin : g_post
      plc_post_div u_post_div (
        .clk    (clk),
        .ce     (ce),
        .srst   (srst),
        .clear  (!running),
        .tick   (vcoTick),
        .divVal (st_reg.postVal[gi]),
        .pulse  (),
        .level  (postLevel[gi])
      );
    end
  endgenerate

  plc_lock_det u_lock_det (
    .clk    (clk),
    .ce     (ce),
    .srst   (srst),
    .clear  (!running || switchEdge),
    .match  (pdMatch),
    .miss   (pdMiss),
    .locked (lockDet)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic speedUp;
    logic slowDown;
    logic access;
    speedUp        = 1'b0;
    slowDown       = 1'b0;
    pdMatch        = 1'b0;
    pdMiss         = 1'b0;
    resync         = 1'b0;
    access         = psel && penable && !st_reg.pready;
    st_next        = st_reg;
    st_next.refPrev = refSel;
    st_next.swPrev  = switchRequest;

    if (switchEdge) begin
      st_next.activeRef = ~st_reg.activeRef; // [RULE7]
    end

    // oscillator and phase comparison
    if (!running) begin
      st_next.vcoCnt    = '0; // [RULE1] [RULE4]
      st_next.vcoPeriod = plc_pkg::VCO_PERIOD_RST; // [RULE3] [RULE5]
      st_next.upPend    = 1'b0;
      st_next.dnPend    = 1'b0;
      st_next.waitCnt   = '0;
    end else begin
      st_next.vcoCnt = vcoTick ? '0 : st_reg.vcoCnt + plc_pkg::VCO_ONE;
      if ((st_reg.upPend || st_reg.dnPend) && st_reg.waitCnt != plc_pkg::WAIT_MAX) begin
        st_next.waitCnt = st_reg.waitCnt + plc_pkg::WAIT_ONE;
      end
      if (refTick && fbTick) begin
        pdMatch        = 1'b1;
        st_next.upPend = 1'b0;
        st_next.dnPend = 1'b0;
      end else if (refTick) begin
        if (st_reg.dnPend) begin
          slowDown       = 1'b1;
          pdMatch        = (st_reg.waitCnt <= plc_pkg::LOCK_WINDOW);
          pdMiss         = !pdMatch;
          st_next.dnPend = 1'b0;
        end else begin
          pdMiss          = st_reg.upPend;
          st_next.upPend  = 1'b1;
          st_next.waitCnt = '0;
        end
      end else if (fbTick) begin
        if (st_reg.upPend) begin
          speedUp        = 1'b1;
          pdMatch        = (st_reg.waitCnt <= plc_pkg::LOCK_WINDOW);
          pdMiss         = !pdMatch;
          st_next.upPend = 1'b0;
        end else begin
          pdMiss          = st_reg.dnPend;
          st_next.dnPend  = 1'b1;
          st_next.waitCnt = '0;
        end
      end
      if (phaseDetEnable && pdMiss) begin
        resync         = 1'b1; // [RULE3]
        st_next.vcoCnt = '0;
        st_next.upPend = 1'b0;
        st_next.dnPend = 1'b0;
        if (speedUp && st_reg.vcoPeriod > plc_pkg::VCO_PERIOD_MIN) begin
          st_next.vcoPeriod = st_reg.vcoPeriod - plc_pkg::VCO_ONE; // [RULE6]
        end else if (slowDown && st_reg.vcoPeriod < plc_pkg::VCO_PERIOD_MAX) begin
          st_next.vcoPeriod = st_reg.vcoPeriod + plc_pkg::VCO_ONE; // [RULE6]
        end
      end
    end

    // register port
    st_next.pready  = access;
    st_next.pslverr = 1'b0;
    st_next.prdata  = '0;
    st_next.irqStat = st_reg.irqStat;
    if (access && pwrite) begin
      if (paddr == plc_pkg::OFS_MULT) begin
        if (inRange(pwdata[plc_pkg::DIV_W-1:0], plc_pkg::MULT_MAX)) begin
          st_next.multVal = pwdata[plc_pkg::DIV_W-1:0]; // [RULE14]
        end
      end else if (paddr == plc_pkg::OFS_PRE) begin
        if (inRange(pwdata[plc_pkg::DIV_W-1:0], plc_pkg::PRE_MAX)) begin
          st_next.preVal = pwdata[plc_pkg::DIV_W-1:0]; // [RULE14]
        end
      end else if (paddr == plc_pkg::OFS_POST0) begin
        if (inRange(pwdata[plc_pkg::DIV_W-1:0], plc_pkg::POST_MAX)) begin
          st_next.postVal[0] = pwdata[plc_pkg::DIV_W-1:0]; // [RULE14]
        end
      end else if (paddr == plc_pkg::OFS_POST1) begin
        if (inRange(pwdata[plc_pkg::DIV_W-1:0], plc_pkg::POST_MAX)) begin
          st_next.postVal[1] = pwdata[plc_pkg::DIV_W-1:0]; // [RULE14]
        end
      end else if (paddr == plc_pkg::OFS_POST2) begin
        if (inRange(pwdata[plc_pkg::DIV_W-1:0], plc_pkg::POST_MAX)) begin
          st_next.postVal[2] = pwdata[plc_pkg::DIV_W-1:0]; // [RULE14]
        end
      end else if (paddr == plc_pkg::OFS_IRQ_MASK) begin
        st_next.irqMask = pwdata[plc_pkg::IRQ_W-1:0];
      end else if (paddr == plc_pkg::OFS_STATUS || paddr == plc_pkg::OFS_IRQ_STAT) begin
        st_next.pslverr = 1'b0;
      end else begin
        st_next.pslverr = 1'b1;
      end
    end else if (access) begin
      if (paddr == plc_pkg::OFS_MULT) begin
        st_next.prdata = widen(st_reg.multVal);
      end else if (paddr == plc_pkg::OFS_PRE) begin
        st_next.prdata = widen(st_reg.preVal);
      end else if (paddr == plc_pkg::OFS_POST0) begin
        st_next.prdata = widen(st_reg.postVal[0]);
      end else if (paddr == plc_pkg::OFS_POST1) begin
        st_next.prdata = widen(st_reg.postVal[1]);
      end else if (paddr == plc_pkg::OFS_POST2) begin
        st_next.prdata = widen(st_reg.postVal[2]);
      end else if (paddr == plc_pkg::OFS_STATUS) begin
        st_next.prdata[plc_pkg::ST_LOCKED]  = st_reg.locked;
        st_next.prdata[plc_pkg::ST_REF_SEL] = st_reg.activeRef;
        st_next.prdata[plc_pkg::ST_RUNNING] = running;
        st_next.prdata[plc_pkg::ST_PD_EN]   = phaseDetEnable;
      end else if (paddr == plc_pkg::OFS_IRQ_STAT) begin
        st_next.prdata[plc_pkg::IRQ_W-1:0] = st_reg.irqStat;
        st_next.irqStat                    = '0;
      end else if (paddr == plc_pkg::OFS_IRQ_MASK) begin
        st_next.prdata[plc_pkg::IRQ_W-1:0] = st_reg.irqMask;
      end else begin
        st_next.pslverr = 1'b1;
      end
    end

    // sticky events, set wins over read clear
    st_next.lockPrev = lockDet;
    if (lockDet && !st_reg.lockPrev) begin
      st_next.irqStat[plc_pkg::IRQ_LOCK_GAIN] = 1'b1;
    end
    if (!lockDet && st_reg.lockPrev) begin
      st_next.irqStat[plc_pkg::IRQ_LOCK_LOSS] = 1'b1;
    end
    if (switchEdge) begin
      st_next.irqStat[plc_pkg::IRQ_SWITCH] = 1'b1;
    end
    st_next.irq = |(st_next.irqStat & st_next.irqMask);

    // outputs
    st_next.clkOut = running ? postLevel : '0; // [RULE2] [RULE4]
    st_next.extClk = running && postLevel[plc_pkg::POST_NUM-1]; // [RULE12]
    st_next.locked = running && lockDet && !switchEdge; // [RULE10] [RULE2]
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg            <= '0;
      st_reg.vcoPeriod  <= plc_pkg::VCO_PERIOD_RST;
      st_reg.multVal    <= plc_pkg::MULT_RST;
      st_reg.preVal     <= plc_pkg::PRE_RST;
      st_reg.postVal[0] <= plc_pkg::POST_RST;
      st_reg.postVal[1] <= plc_pkg::POST_RST;
      st_reg.postVal[2] <= plc_pkg::POST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign clkOut    = st_reg.clkOut;
  assign extClkOut = st_reg.extClk;
  assign locked    = st_reg.locked;
  assign irq       = st_reg.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_enable_resets: assert property (@(posedge clk) disable iff (srst) // [RULE1]
    (ce && !pllEnable) |=> (st_reg.vcoPeriod == plc_pkg::VCO_PERIOD_RST && !st_reg.upPend && !st_reg.dnPend))
    else $error("loop not reset while disabled");

  a_disable_outputs_low: assert property (@(posedge clk) disable iff (srst) // [RULE2]
    (ce && !pllEnable) |=> (clkOut == '0 && !extClkOut && !locked))
    else $error("outputs active while disabled");

  a_fresh_acquire: assert property (@(posedge clk) disable iff (srst) // [RULE3]
    (ce && !pllEnable) ##1 (ce && pllEnable && !counterReset) |=> !locked)
    else $error("lock held across re-enable");

  a_counter_reset: assert property (@(posedge clk) disable iff (srst) // [RULE4]
    (ce && counterReset) |=> (clkOut == '0 && !locked && st_reg.vcoCnt == '0))
    else $error("counter reset did not clear");

  a_reset_release: assert property (@(posedge clk) disable iff (srst) // [RULE5]
    (ce && counterReset) ##1 (ce && pllEnable && !counterReset) |=> (!locked && st_reg.vcoCnt != '0))
    else $error("no restart after counter reset");

  a_pd_gated: assert property (@(posedge clk) disable iff (srst) // [RULE6]
    (ce && !phaseDetEnable && running) |=> (st_reg.vcoPeriod == $past(st_reg.vcoPeriod)))
    else $error("oscillator adjusted with detector off");

  a_switch_toggles: assert property (@(posedge clk) disable iff (srst) // [RULE7]
    (ce && switchRequest && !st_reg.swPrev) |=> (st_reg.activeRef != $past(st_reg.activeRef)))
    else $error("switchover not taken");

  a_ext_mirror: assert property (@(posedge clk) disable iff (srst) // [RULE12]
    extClkOut == clkOut[plc_pkg::POST_NUM-1])
    else $error("external clock differs from third output");

  a_div_range: assert property (@(posedge clk) disable iff (srst) // [RULE14]
    inRange(st_reg.multVal, plc_pkg::MULT_MAX) && inRange(st_reg.preVal, plc_pkg::PRE_MAX))
    else $error("divider setting out of range");

endmodule

/* File: verification/plc_ref_src.sv */
// reference clocks standing in for the dedicated clock pins
`timescale 1ns/10ps
module plc_ref_src #(
  parameter int PERIOD = 32
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      refPrimary = 1'b0,
  output logic      refSecondary = 1'b0
);
  int cnt = 0;
  // each reference from its own pin, same rate, shifted phase
  always @(posedge clk) begin
    cnt <= (srst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    refPrimary <= !srst && (cnt < PERIOD / 2);
    refSecondary <= !srst && (cnt >= PERIOD / 4) && (cnt < 3 * PERIOD / 4);
  end
endmodule

/* File: verification/plc_loop_ctrl_bench.sv */
// register and control pin tests of the loop control block
`timescale 1ns/10ps
module plc_loop_ctrl_bench;
  logic        clk = 1'b0, srst = 1'b1, pllEnable = 1'b0, counterReset = 1'b0;
  logic        phaseDetEnable = 1'b0, switchRequest = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, extClkOut, locked, irq, refPrimary, refSecondary, err;
  logic [2:0]  clkOut;
  int          n_errors = 0, n_checks = 0;
  always #4 clk = ~clk;
  plc_ref_src #(.PERIOD(32)) ref_src (.clk, .srst, .refPrimary, .refSecondary);
  plc_loop_ctrl dut (.clk, .ce(1'b1), .srst, .pllEnable, .counterReset, .phaseDetEnable, .switchRequest,
    .refPrimary, .refSecondary, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .clkOut, .extClkOut, .locked, .irq);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_lock;
    int t, run;
    t = 0;
    run = 0;
    while (run < 4 && t < 3000) begin
      @(posedge clk);
      t++;
      run = (locked === 1'b1) ? run + 1 : 0;
    end
    chk("locked", 32'h1, {31'h0, run == 4});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    end_sim;
  end
  initial begin
    logic [7:0]  ta [9];
    logic [31:0] tw [9];
    logic [31:0] te [9];
    int          tg, hit;
    ta = '{plc_pkg::OFS_MULT, plc_pkg::OFS_MULT, plc_pkg::OFS_MULT, plc_pkg::OFS_PRE, plc_pkg::OFS_PRE,
           plc_pkg::OFS_POST0, plc_pkg::OFS_POST2, plc_pkg::OFS_MULT, plc_pkg::OFS_PRE};
    tw = '{32'h21, 32'h0, 32'h20, 32'h5, 32'h4, 32'h21, 32'h1, 32'h4, 32'h1};
    te = '{32'h4, 32'h4, 32'h20, 32'h1, 32'h4, 32'h2, 32'h1, 32'h4, 32'h1};
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    pllEnable <= 1'b1;
    phaseDetEnable <= 1'b1;
    apb(1'b0, plc_pkg::OFS_POST1, 32'h0);
    chk("post1 reset", 32'h2, rd);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, ta[i], tw[i]);
      apb(1'b0, ta[i], 32'h0);
      chk("divider", te[i], rd);
    end
    apb(1'b1, 8'h20, 32'h1);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test dividers done");
    wait_lock;
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, plc_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'hc, rd & 32'he);
    apb(1'b1, plc_pkg::OFS_IRQ_MASK, 32'h4);
    apb(1'b0, plc_pkg::OFS_IRQ_STAT, 32'h0);
    switchRequest <= 1'b1;
    repeat (3) @(posedge clk);
    chk("switch lock", 32'h0, {31'h0, locked});
    chk("switch irq", 32'h1, {31'h0, irq});
    switchRequest <= 1'b0;
    apb(1'b0, plc_pkg::OFS_STATUS, 32'h0);
    chk("active ref", 32'h2, rd & 32'h2);
    apb(1'b0, plc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("switch stat", 32'h4, rd & 32'h4);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test switchover done");
    phaseDetEnable <= 1'b0;
    tg = 0;
    hit = 0;
    repeat (200) begin
      @(posedge clk);
      if (extClkOut !== clkOut[2]) hit++;
      if (clkOut[1] !== clkOut[0]) hit++;
      tg += (clkOut[0] === 1'b1);
    end
    chk("free run", 32'h1, {31'h0, tg > 0 && tg < 200});
    chk("ext copy", 32'h0, hit);
    phaseDetEnable <= 1'b1;
    $display("test free run done");
    for (int i = 0; i < 2; i++) begin
      if (i == 0) pllEnable <= 1'b0;
      else counterReset <= 1'b1;
      repeat (2) @(posedge clk);
      hit = 0;
      repeat (50) begin
        @(posedge clk);
        hit += (clkOut !== 3'h0) || (extClkOut !== 1'b0) || (locked !== 1'b0);
      end
      chk("held low", 32'h0, hit);
      pllEnable <= 1'b1;
      counterReset <= 1'b0;
      wait_lock;
    end
    $display("test resets done");
    end_sim;
  end
endmodule
